// ### hw/mfr_pkg.sv
// How it works
// [R1] Without skipping, frame needs 32 ones first
// [R2] Skip enable resets zero, written only after override
// [R3] Skipping enabled: frame may start at delimiter
// [R4] Start delimiter is zero then one
// [R5] Opcode 10 reads, 01 writes, others ignored
// [R6] Respond only when PHY address matches
// [R7] Register address selects one of 32
// [R8] Read turnaround: release, then drive low
// [R9] Write turnaround: manager drives one then zero
// [R10] Matching read shifts out addressed register
// [R11] Matching write stores sixteen data bits; status register takes only the skip bit
// [R12] Unimplemented register reads as all ones
// [R13] Unimplemented register write changes nothing but the override bit
// [R14] Data goes most significant bit first
// [R15] Idle link: data line not driven
// [R16] Back-to-back frames need no idle bit
// [R17] Override clears on the next write
// [R18] Sample on rising edge, change after it
// [R19] Address mismatch: stay off whole frame
package mfr_pkg;
	localparam int PRE_LEN = 32;
	localparam logic [5:0] PRE_MAX = 6'h20;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_STAT = 5'h01;
	localparam logic [4:0] REG_EXT = 5'h10;
	localparam int SKIP_BIT = 6;
	localparam int OVR_BIT = 15;
	localparam int PHYAD_LSB = 6;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] STAT_RST = 16'h0000;
	localparam logic [15:0] EXT_RST = 16'h0000;
	localparam logic [15:0] NO_REG = 16'hFFFF;
	localparam logic [4:0] HDR_BITS = 5'h0E;
	localparam logic [4:0] DATA_BITS = 5'h10;
	localparam logic [4:0] HDR_END = 5'h0C;
	localparam logic [4:0] DATA_END = 5'h0F;
	localparam logic [4:0] SKIP_END = 5'h11;
	typedef enum logic [2:0]
	{
		ST_HUNT = 3'h0,
		ST_HDR = 3'h1,
		ST_TA = 3'h3,
		ST_DATA = 3'h2,
		ST_SKIP = 3'h6
	} mfr_state_e;
endpackage

// ### hw/mfr_sync.sv
`timescale 1ns/1ns
// Two-flop synchroniser for one pin level
module mfr_sync
	import mfr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic d_i,
	output logic q_o
);
	logic meta_r;
	// First stage feeds only the second stage
	// Resets to the idle-high pin level, so no false edge follows reset
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_r <= 1'b1;
			q_o <= 1'b1;
		end
		else
		begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule

// ### hw/mfr_top.sv
`timescale 1ns/1ns
// Management frame responder, sampling the link clock with the core clock
module mfr_top
	import mfr_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic MDC_I,
	input wire logic MDIO_I,
	output logic MDIO_O,
	output logic MDIO_OE_O,
	output logic PRE_SKIP_O,
	output logic [4:0] PHYAD_O
);
	logic mdc_s, mdio_s, mdc_d_r;
	mfr_state_e st_r, st_nxt;
	logic [5:0] ones_r;
	logic [4:0] cnt_r;
	logic [13:0] hdr_r;
	logic [15:0] sh_r;
	logic ta1_r;
	logic [15:0] ctrl_r, stat_r, ext_r;
	logic [15:0] rd_val;

	////////////////////////////////////////////////////////////////
	// Pin synchronisers
	mfr_sync u_sync_mdc
	(
		.clk_i(CORE_CLK_I),
		.rst_i(SYS_RST_I),
		.d_i(MDC_I),
		.q_o(mdc_s)
	);
	mfr_sync u_sync_mdio
	(
		.clk_i(CORE_CLK_I),
		.rst_i(SYS_RST_I),
		.d_i(MDIO_I),
		.q_o(mdio_s)
	);

	////////////////////////////////////////////////////////////////
	// Edge finding and frame field decode
	wire rise = mdc_s & ~mdc_d_r; // see [R18]
	wire fall = ~mdc_s & mdc_d_r;
	wire skip_en = stat_r[SKIP_BIT];
	wire pre_ok = (ones_r == PRE_MAX) || skip_en; // see [R1] see [R3]
	wire start_seen = rise && !mdio_s && pre_ok; // see [R4]
	wire [13:0] hdr_full = {hdr_r[12:0], mdio_s};
	// Thirteen header bits land in [12:0]; bit 13 takes the read flag on the first turnaround rise
	wire [1:0] op_in = hdr_full[11:10];
	wire [1:0] op = hdr_r[11:10];
	wire [4:0] rad = hdr_r[4:0];
	wire rd_flag = hdr_r[13];
	wire op_rd = (op == OP_READ); // see [R5]
	wire op_ok = (op_in == OP_READ) || (op_in == OP_WRITE); // see [R5]
	wire ad_ok = (hdr_full[9:5] == ext_r[PHYAD_LSB +: 5]); // see [R6]
	wire hit = hdr_full[12] && ad_ok && op_ok; // see [R4] see [R19]
	wire reg_ok = (rad == REG_CTRL) || (rad == REG_STAT)
		|| (rad == REG_EXT);
	wire wr_done = (st_r == ST_DATA) && rise && (cnt_r == DATA_END)
		&& !rd_flag;
	wire [15:0] wr_data = {sh_r[14:0], mdio_s}; // see [R14]
	wire ovr = ext_r[OVR_BIT];

	// Read source selection; holes read as ones
	assign rd_val = (rad == REG_CTRL) ? ctrl_r :
		(rad == REG_STAT) ? stat_r :
		(rad == REG_EXT) ? ext_r : NO_REG; // see [R7] see [R12]

	////////////////////////////////////////////////////////////////
	// State sequencing
	always_comb
	begin
		st_nxt = st_r;
		unique case (st_r)
			ST_HUNT:
				if (start_seen)
					st_nxt = ST_HDR;
			ST_HDR:
				if (rise && cnt_r == HDR_END)
					st_nxt = hit ? ST_TA : ST_SKIP; // see [R19]
			ST_TA:
				if (rise && ta1_r)
					st_nxt = ST_DATA;
			ST_DATA:
				if (rise && cnt_r == DATA_END)
					st_nxt = ST_HUNT; // see [R16]
			ST_SKIP:
				if (rise && cnt_r == SKIP_END)
					st_nxt = ST_HUNT;
			default:
				st_nxt = ST_HUNT;
		endcase
	end

	// Header is shifted in; bit 13 of hdr_r marks a read once framed
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			st_r <= ST_HUNT;
			mdc_d_r <= 1'b1;
			ones_r <= 6'h00;
			cnt_r <= 5'h00;
			hdr_r <= 14'h0000;
			sh_r <= 16'h0000;
			ta1_r <= 1'b0;
		end
		else
		begin
			mdc_d_r <= mdc_s;
			st_r <= st_nxt;
			if (rise && st_r == ST_HUNT)
			begin
				ones_r <= mdio_s ? (ones_r == PRE_MAX ? ones_r
					: ones_r + 6'h01) : 6'h00;
				hdr_r <= 14'h2000;
				cnt_r <= 5'h00;
			end
			else if (rise && st_r == ST_HDR)
			begin
				hdr_r <= hdr_full;
				cnt_r <= cnt_r + 5'h01;
				if (cnt_r == HDR_END)
				begin
					ta1_r <= 1'b0;
					cnt_r <= 5'h00;
					ones_r <= 6'h00;
				end
			end
			else if (rise && st_r == ST_TA)
			begin
				ta1_r <= 1'b1;
				hdr_r[13] <= op_rd;
				if (ta1_r)
					sh_r <= rd_val; // see [R10]
			end
			else if (rise && st_r == ST_DATA)
			begin
				cnt_r <= cnt_r + 5'h01;
				sh_r <= wr_data; // see [R11]
			end
			else if (rise && st_r == ST_SKIP)
				cnt_r <= cnt_r + 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////
	// Register store with gated skip enable
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			ctrl_r <= CTRL_RST;
			stat_r <= STAT_RST; // see [R2]
			ext_r <= EXT_RST;
		end
		else if (wr_done && reg_ok) // see [R13]
		begin
			if (rad == REG_CTRL)
				ctrl_r <= wr_data;
			if (rad == REG_STAT && ovr)
				stat_r[SKIP_BIT] <= wr_data[SKIP_BIT]; // see [R2]
			if (rad == REG_EXT)
				ext_r <= wr_data;
			else
				ext_r[OVR_BIT] <= 1'b0; // see [R17]
			if (rad == REG_EXT && ovr)
				ext_r[OVR_BIT] <= 1'b0; // see [R17]
		end
		else if (wr_done && ovr)
			ext_r[OVR_BIT] <= 1'b0; // see [R17]
	end

	// Pin drive changes on the falling edge, well after sampling, and ends on the last data rise
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			MDIO_O <= 1'b0;
			MDIO_OE_O <= 1'b0; // see [R15]
			PRE_SKIP_O <= 1'b0;
			PHYAD_O <= 5'h00;
		end
		else
		begin
			PRE_SKIP_O <= skip_en;
			PHYAD_O <= ext_r[PHYAD_LSB +: 5];
			if (fall)
			begin
				if (st_r == ST_TA && ta1_r && rd_flag)
				begin
					MDIO_OE_O <= 1'b1; // see [R8]
					MDIO_O <= 1'b0;
				end
				else if (st_r == ST_DATA && rd_flag)
				begin
					MDIO_OE_O <= 1'b1;
					MDIO_O <= sh_r[15]; // see [R10] see [R14]
				end
				else
					MDIO_OE_O <= 1'b0; // see [R9] see [R15]
			end
			// Release after the last data rise: the link clock may stop
			else if (rise && st_r == ST_DATA && cnt_r == DATA_END)
				MDIO_OE_O <= 1'b0; // see [R15]
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	AST_IDLE_OFF: assert property (@(posedge CORE_CLK_I) // see [R15]
		disable iff (SYS_RST_I) (st_r == ST_HUNT && $past(st_r)
		== ST_HUNT && fall) |=> !MDIO_OE_O)
		else $error("line driven while idle");
	AST_SKIP_OFF: assert property (@(posedge CORE_CLK_I) // see [R19]
		disable iff (SYS_RST_I) (st_r == ST_SKIP && fall) |=> !MDIO_OE_O)
		else $error("line driven on foreign frame");
	AST_SKIP_RST: assert property (@(posedge CORE_CLK_I) // see [R2]
		disable iff (SYS_RST_I) (wr_done && !ovr) |=> $stable(skip_en))
		else $error("skip enable changed without override");
	AST_OVR_CLR: assert property (@(posedge CORE_CLK_I) // see [R17]
		disable iff (SYS_RST_I) (wr_done && ovr) |=> !ext_r[OVR_BIT])
		else $error("override not cleared");
	AST_TA_LOW: assert property (@(posedge CORE_CLK_I) // see [R8]
		disable iff (SYS_RST_I) (st_r == ST_TA && ta1_r && rd_flag
		&& fall) |=> MDIO_OE_O && !MDIO_O)
		else $error("turnaround not driven low");
	AST_NOWR_HOLE: assert property (@(posedge CORE_CLK_I) // see [R13]
		disable iff (SYS_RST_I) (wr_done && !reg_ok) |=>
		$stable(ctrl_r) && $stable(stat_r))
		else $error("hole write changed a register");
	AST_HDR_BAD: assert property (@(posedge CORE_CLK_I) // see [R5]
		disable iff (SYS_RST_I) (st_r == ST_HDR && rise
		&& cnt_r == HDR_END && op_in == 2'h3) |=> st_r == ST_SKIP)
		else $error("bad opcode accepted");
	AST_NO_PRE: assert property (@(posedge CORE_CLK_I) // see [R1]
		disable iff (SYS_RST_I) (st_r == ST_HUNT && !skip_en
		&& ones_r < PRE_MAX) |=> st_r == ST_HUNT)
		else $error("frame without preamble");
	AST_END_OFF: assert property (@(posedge CORE_CLK_I) // see [R15]
		disable iff (SYS_RST_I) (st_r == ST_DATA && rise
		&& cnt_r == DATA_END) |=> !MDIO_OE_O)
		else $error("line still driven after data");
	COV_READ: cover property (@(posedge CORE_CLK_I)
		st_r == ST_DATA && rd_flag);
	COV_WRITE: cover property (@(posedge CORE_CLK_I) wr_done);
	COV_SKIP: cover property (@(posedge CORE_CLK_I) st_r == ST_SKIP);
endmodule

// ### bench/mfr_sta_model.sv
`timescale 1ns/1ns
// Manager model: link clock runs only inside frames
module mfr_sta_model
	import mfr_pkg::*;
(
	input wire logic clk_i,
	input wire logic dev_d_i,
	input wire logic dev_oe_i,
	output logic mdc_o,
	output logic mdio_o
);
	logic drv = 1'b0;
	logic d = 1'b0;
	logic seen = 1'b0;
	initial mdc_o = 1'b1;
	// Pull-up wins when nobody drives the line
	assign mdio_o = dev_oe_i ? dev_d_i : (drv ? d : 1'b1);
	// Any device drive is remembered until the bench clears it
	always @(posedge clk_i)
		if (dev_oe_i)
			seen <= 1'b1;
	////////////////////////////////
	// One bit time: change while low, sample in the high phase
	// Sampling before the responder sees the rise avoids a same-step race
	task automatic bit_cyc(input logic en, input logic b, output logic s);
		mdc_o <= 1'b0;
		drv <= en;
		d <= b;
		repeat (4) @(posedge clk_i);
		mdc_o <= 1'b1;
		repeat (2) @(posedge clk_i);
		s = mdio_o;
		repeat (2) @(posedge clk_i);
	endtask
	// Whole frame; n ones of preamble, zero when skipping
	task automatic frame(input int n, input logic [1:0] op,
		input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rd, output logic [1:0] ta);
		logic [13:0] hdr;
		logic s;
		logic rdop;
		hdr = {2'b01, op, pa, ra};
		rdop = (op == OP_READ);
		repeat (n) bit_cyc(1'b1, 1'b1, s);
		for (int i = 13; i >= 0; i--)
			bit_cyc(1'b1, hdr[i], s);
		bit_cyc(!rdop, 1'b1, ta[1]);
		bit_cyc(!rdop, 1'b0, ta[0]);
		for (int i = 15; i >= 0; i--)
			bit_cyc(!rdop, wd[i], rd[i]);
	endtask
endmodule

// ### bench/mdio_frame_responder_test.sv
`timescale 1ns/1ns
// Frame-level checks of the management responder
module mdio_frame_responder_test
	import mfr_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic mdc, mdio, d_o, oe_o, skip_o;
	logic [4:0] phyad_o;
	logic [15:0] rd;
	logic [1:0] ta;
	int err_count = 0;
	int tests_run = 0;
	// Rows: opcode, register, write data, expected read data
	localparam logic [38:0] ROWS [9] = '{
		{OP_WRITE, 5'h00, 16'hA5C3, 16'h0000},
		{OP_READ, 5'h00, 16'h0000, 16'hA5C3},
		{OP_READ, 5'h05, 16'h0000, 16'hFFFF},
		{OP_WRITE, 5'h05, 16'h1234, 16'h0000},
		{2'h0, 5'h00, 16'h1111, 16'h0000},
		{2'h3, 5'h00, 16'h2222, 16'h0000},
		{OP_READ, 5'h00, 16'h0000, 16'hA5C3},
		{OP_WRITE, 5'h00, 16'h5A3C, 16'h0000},
		{OP_READ, 5'h00, 16'h0000, 16'h5A3C}
	};
	// Core clock, 10 ns period
	initial
	begin
		forever #5 clk = ~clk;
	end
	mfr_top u_dut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .MDC_I(mdc),
		.MDIO_I(mdio), .MDIO_O(d_o), .MDIO_OE_O(oe_o),
		.PRE_SKIP_O(skip_o), .PHYAD_O(phyad_o));
	mfr_sta_model u_sta (.clk_i(clk), .dev_d_i(d_o), .dev_oe_i(oe_o),
		.mdc_o(mdc), .mdio_o(mdio));
	////////////////////////////////
	// Compare tasks for data words and single flags
	task automatic chk_d(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_f(input logic got, input logic exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// One frame with the drive monitor cleared first
	task automatic fr(input int n, input logic [1:0] op, input logic [4:0] pa,
		input logic [4:0] ra, input logic [15:0] wd);
		u_sta.seen = 1'b0;
		u_sta.frame(n, op, pa, ra, wd, rd, ta);
	endtask
	////////////////////////////////
	// Main sequence; rows run back to back with no idle bit
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		chk_d({10'h0, phyad_o, skip_o}, 16'h0000);
		chk_f(oe_o, 1'b0);
		$display("test reset done");
		for (int k = 0; k < 9; k++)
		begin
			fr(32, ROWS[k][38:37], 5'h00, ROWS[k][36:32], ROWS[k][31:16]);
			chk_f(u_sta.seen, ROWS[k][38:37] == OP_READ);
			if (ROWS[k][38:37] == OP_READ)
			begin
				chk_d(rd, ROWS[k][15:0]);
				chk_d({14'h0, ta}, 16'h0002);
			end
		end
		$display("test rows done");
		// Skip enable refused until the override is set, once only
		fr(32, OP_WRITE, 5'h00, REG_STAT, 16'h0040);
		repeat (6) @(posedge clk);
		chk_f(skip_o, 1'b0);
		fr(32, OP_WRITE, 5'h00, REG_EXT, 16'h8000);
		fr(32, OP_WRITE, 5'h00, REG_STAT, 16'h0040);
		repeat (6) @(posedge clk);
		chk_f(skip_o, 1'b1);
		fr(32, OP_READ, 5'h00, REG_EXT, 16'h0000);
		chk_d(rd, 16'h0000);
		fr(0, OP_WRITE, 5'h00, REG_CTRL, 16'h0F0F);
		fr(0, OP_READ, 5'h00, REG_CTRL, 16'h0000);
		chk_d(rd, 16'h0F0F);
		$display("test skip done");
		// Skipping off again, then a preamble one short
		fr(0, OP_WRITE, 5'h00, REG_EXT, 16'h8000);
		fr(0, OP_WRITE, 5'h00, REG_STAT, 16'h0000);
		repeat (6) @(posedge clk);
		chk_f(skip_o, 1'b0);
		fr(31, OP_READ, 5'h00, REG_CTRL, 16'h0000);
		chk_f(u_sta.seen, 1'b0);
		$display("test short preamble done");
		// New stored address; the old one is then ignored
		fr(32, OP_WRITE, 5'h00, REG_EXT, 16'h04C0);
		repeat (6) @(posedge clk);
		chk_d({11'h0, phyad_o}, 16'h0013);
		fr(32, OP_READ, 5'h00, REG_CTRL, 16'h0000);
		chk_f(u_sta.seen, 1'b0);
		fr(32, OP_READ, 5'h13, REG_CTRL, 16'h0000);
		chk_d(rd, 16'h0F0F);
		repeat (6) @(posedge clk);
		chk_f(oe_o, 1'b0);
		$display("test address done");
		// Reset in mid-run puts the address and registers back
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		chk_d({10'h0, phyad_o, skip_o}, 16'h0000);
		fr(32, OP_READ, 5'h00, REG_CTRL, 16'h0000);
		chk_f(u_sta.seen, 1'b1);
		chk_d(rd, CTRL_RST);
		$display("test mid reset done");
		conclude();
	end
	// Watchdog well beyond the expected run of about 10300 cycles
	initial
	begin
		repeat (40000) @(posedge clk);
		err_count++;
		conclude();
	end
endmodule
